// file: rtl/emb_bus_ctrl.sv
// Summary of operation
// R1 - Space selects idle high; only the addressed space select goes low during access.
// R2 - Direction qualifier high by default, low only during an external write.
// R3 - Inverse direction qualifier low by default, high only during a write.
// R4 - Read strobe low on every external program, data or I/O read.
// R5 - Write strobe low on every write; its fall coincides with data drive.
// R6 - External-cycle strobe idle high, low for every off-chip access.
// R7 - Ready low from outside adds a wait state; ready rechecked each cycle.
// R8 - Ready sampled only when at least one software wait state is programmed.
// R9 - Boot select low at reset: microcomputer mode, internal program memory at 0000h.
// R10 - Boot select high at reset: microprocessor mode, external program at 0000h.
// R11 - Boot select level caught at reset is shown in status register bit 2.
// R12 - Interface enable low disables bus; data space access raises illegal address.
// R13 - Visibility output enable low while data bus is driven in visibility mode.
// R14 - Outside decode may use visibility enable to keep other drivers off.
// R15 - Sixteen-bit address bus, address line zero carries bit 0.
// R16 - Bus control outputs can be placed in high impedance.
// R17 - Tristate only when emulation off low, test reset low, emulation pin 0 high.
// R18 - Select, cycle strobe and read/write strobe held for whole access incl. waits.
`timescale 1ns/1ns
`include "emb_params.svh"

module emb_bus_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Mode and emulation pins
  input  wire logic        boot_memory_select_i,
  input  wire logic        external_interface_enable_pin_i,
  input  wire logic        emulation_pin_0_i,
  input  wire logic        emulation_pin_1_off_i,
  input  wire logic        test_reset_i,
  input  wire logic        ready_i,
  // Boot mode
  output logic             boot_external_o,
  output logic [15:0]      reset_vector_o,
  // External bus control
  output logic             program_space_strobe_n_o,
  output logic             data_space_strobe_n_o,
  output logic             io_space_strobe_n_o,
  output logic             read_write_o,
  output logic             write_read_o,
  output logic             read_strobe_n_o,
  output logic             write_strobe_n_o,
  output logic             external_cycle_strobe_n_o,
  output logic             bus_ctrl_oe_n_o,
  output logic             visibility_output_enable_n_o,
  // External address and data
  output logic [15:0]      ext_addr_o,
  input  wire logic [15:0] external_data_bus_i,
  output logic [15:0]      external_data_bus_o,
  output logic             external_data_bus_oe_n_o
);

  emb_pkg::emb_state_e state_reg;
  emb_pkg::emb_space_e space_reg;
  logic [8:0]          wait_ctrl_reg;
  logic [15:0]         addr_reg;
  logic [15:0]         wdata_reg;
  logic [15:0]         rdata_reg;
  logic                write_reg;
  logic                vis_reg;
  logic                done_reg;
  logic                illegal_reg;
  logic                boot_reg;
  logic                aw_got_reg;
  logic                w_got_reg;
  logic [7:0]          awaddr_reg;
  logic [31:0]         wdata_bus_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic                rvalid_reg;
  logic [1:0]          rresp_reg;
  logic [31:0]         rdata_bus_reg;

  // Register bus decode
  wire        aw_hs      = s_axi_awvalid & s_axi_awready;
  wire        w_hs       = s_axi_wvalid & s_axi_wready;
  wire        ar_hs      = s_axi_arvalid & s_axi_arready;
  wire        wr_fire    = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire        wr_wait    = wr_fire & (awaddr_reg == `EMB_OFF_WAIT_CTRL);
  wire        wr_addr    = wr_fire & (awaddr_reg == `EMB_OFF_ADDR);
  wire        wr_wdat    = wr_fire & (awaddr_reg == `EMB_OFF_WDATA);
  wire        wr_ctrl    = wr_fire & (awaddr_reg == `EMB_OFF_CTRL);
  wire        wr_stat    = wr_fire & (awaddr_reg == `EMB_OFF_STATUS);
  wire        wr_ro      = (awaddr_reg == `EMB_OFF_SYS_CS2) | (awaddr_reg == `EMB_OFF_RDATA);
  wire        wr_mapped  = wr_ro | (awaddr_reg == `EMB_OFF_WAIT_CTRL) |
                           (awaddr_reg == `EMB_OFF_ADDR) | (awaddr_reg == `EMB_OFF_WDATA) |
                           (awaddr_reg == `EMB_OFF_CTRL) | (awaddr_reg == `EMB_OFF_STATUS);
  wire [31:0] wd         = wdata_bus_reg;

  // Access launch
  wire        go         = wr_ctrl & wd[`EMB_CTRL_GO_BIT];
  wire        busy       = (state_reg == emb_pkg::EMB_ACCESS);
  wire [1:0]  go_space   = wd[`EMB_CTRL_SPACE_LSB +: 2];
  wire        go_bad     = (go_space == emb_pkg::EMB_SPACE_BAD);
  wire        if_en      = external_interface_enable_pin_i;
  wire        launch     = go & ~busy & if_en & ~go_bad;                       // see R12
  // With the interface off there is no external memory; a data access is illegal
  wire        set_ill    = go & ~busy & (go_bad |
                           (~if_en & (go_space == emb_pkg::EMB_SPACE_DATA)));  // see R12
  wire        refused    = go & ~busy & ~launch;
  wire [2:0]  ws_prog    = wait_ctrl_reg[`EMB_WS_PROG_LSB +: 3];
  wire [2:0]  ws_data    = wait_ctrl_reg[`EMB_WS_DATA_LSB +: 3];
  wire [2:0]  ws_io      = wait_ctrl_reg[`EMB_WS_IO_LSB +: 3];
  wire [2:0]  ws_sel     = (go_space == emb_pkg::EMB_SPACE_PROG) ? ws_prog :
                           (go_space == emb_pkg::EMB_SPACE_DATA) ? ws_data : ws_io;
  logic       acc_done;
  logic [2:0] wait_count;
  logic       ready_sample;

  emb_wait_gen u_wait (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .start_i  (launch),
    .ws_i     (ws_sel),
    .ready_i  (ready_i),
    .done_o   (acc_done),
    .count_o  (wait_count),
    .sample_o (ready_sample)
  );

  // Pin decode; strobes stay put for the whole access, wait states included
  wire acc_wr = busy & write_reg;
  wire acc_rd = busy & ~write_reg;
  assign program_space_strobe_n_o  = ~(busy & (space_reg == emb_pkg::EMB_SPACE_PROG)); // see R1 R18
  assign data_space_strobe_n_o     = ~(busy & (space_reg == emb_pkg::EMB_SPACE_DATA)); // see R1 R18
  assign io_space_strobe_n_o       = ~(busy & (space_reg == emb_pkg::EMB_SPACE_IO));   // see R1 R18
  assign read_write_o              = ~acc_wr;                                         // see R2
  assign write_read_o              = acc_wr;                                          // see R3
  assign read_strobe_n_o           = ~acc_rd;                                         // see R4 R18
  // Data drive and write strobe share one enable so the edges line up
  assign write_strobe_n_o          = ~acc_wr;                                         // see R5 R18
  assign external_data_bus_oe_n_o  = ~acc_wr;                                         // see R5
  assign external_cycle_strobe_n_o = ~busy;                                           // see R6 R18
  assign visibility_output_enable_n_o = ~(acc_wr & vis_reg);                          // see R13
  // Float only in the emulation condition; the board pulls the pins meanwhile
  assign bus_ctrl_oe_n_o = ~emulation_pin_1_off_i & ~test_reset_i & emulation_pin_0_i; // see R16 R17
  assign ext_addr_o          = addr_reg;                                              // see R15
  assign external_data_bus_o = wdata_reg;
  assign boot_external_o     = boot_reg;                                              // see R9 R10
  assign reset_vector_o      = `EMB_RESET_VECTOR;                                     // see R9 R10

  // AXI4-Lite handshake outputs
  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_bus_reg;

  // Read mux
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      `EMB_OFF_WAIT_CTRL: rd_mux[8:0] = wait_ctrl_reg;
      `EMB_OFF_SYS_CS2:   rd_mux[`EMB_BOOT_BIT] = boot_reg;                      // see R11
      `EMB_OFF_ADDR:      rd_mux[15:0] = addr_reg;
      `EMB_OFF_WDATA:     rd_mux[15:0] = wdata_reg;
      `EMB_OFF_CTRL: begin
        rd_mux[`EMB_CTRL_SPACE_LSB +: 2] = space_reg;
        rd_mux[`EMB_CTRL_WRITE_BIT]      = write_reg;
        rd_mux[`EMB_CTRL_VIS_BIT]        = vis_reg;
      end
      `EMB_OFF_STATUS: begin
        rd_mux[`EMB_ST_BUSY_BIT] = busy;
        rd_mux[`EMB_ST_DONE_BIT] = done_reg;
        rd_mux[`EMB_ST_ILL_BIT]  = illegal_reg;
      end
      `EMB_OFF_RDATA:     rd_mux[15:0] = rdata_reg;
      default:            rd_ok = 1'b0;
    endcase
  end

  // AXI4-Lite channel state
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_bus_reg <= 32'h0000_0000;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `EMB_RESP_OKAY;
      rvalid_reg    <= 1'b0;
      rresp_reg     <= `EMB_RESP_OKAY;
      rdata_bus_reg <= 32'h0000_0000;
    end else begin
      if (aw_hs) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_reg     <= 1'b1;
        wdata_bus_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_reg    <= 1'b1;
        rdata_bus_reg <= rd_mux;
        rresp_reg     <= rd_ok ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Software registers; writes to the words below land only when both low byte-lane strobes are set
  wire lane_lo = &s_axi_wstrb[1:0];
  logic wstrb_lo_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wstrb_lo_reg  <= 1'b0;
      wait_ctrl_reg <= `EMB_WAIT_RESET;
      addr_reg      <= 16'h0000;
      wdata_reg     <= 16'h0000;
      vis_reg       <= 1'b0;
    end else begin
      if (w_hs) begin
        wstrb_lo_reg <= lane_lo;
      end
      if (wr_wait && wstrb_lo_reg) begin
        wait_ctrl_reg <= wd[8:0];
      end
      // Address and data are frozen while a cycle runs
      if (wr_addr && wstrb_lo_reg && !busy) begin
        addr_reg <= wd[15:0];
      end
      if (wr_wdat && wstrb_lo_reg && !busy) begin
        wdata_reg <= wd[15:0];
      end
      if (wr_ctrl && wstrb_lo_reg) begin
        vis_reg <= wd[`EMB_CTRL_VIS_BIT];
      end
    end
  end

  // Bus cycle state and sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg   <= emb_pkg::EMB_IDLE;
      space_reg   <= emb_pkg::EMB_SPACE_PROG;
      write_reg   <= 1'b0;
      rdata_reg   <= 16'h0000;
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        emb_pkg::EMB_IDLE: begin
          if (launch) begin
            state_reg <= emb_pkg::EMB_ACCESS;
            space_reg <= emb_pkg::emb_space_e'(go_space);
            write_reg <= wd[`EMB_CTRL_WRITE_BIT];
          end
        end
        emb_pkg::EMB_ACCESS: begin
          if (acc_done) begin                                                  // see R7
            state_reg <= emb_pkg::EMB_IDLE;
            if (!write_reg) begin
              rdata_reg <= external_data_bus_i;
            end
          end
        end
      endcase
      if (acc_done || refused) begin
        done_reg <= 1'b1;
      end else if (wr_stat && wd[`EMB_ST_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (set_ill) begin                                                       // see R12
        illegal_reg <= 1'b1;
      end else if (wr_stat && wd[`EMB_ST_ILL_BIT]) begin
        illegal_reg <= 1'b0;
      end
    end
  end

  // Boot level caught on every clocked edge while reset is held
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      boot_reg <= boot_memory_select_i;                                        // see R11
    end
  end

  // Checks
  sequence s_launch_ws0;
    launch && (ws_sel == `EMB_WS_ZERO);
  endsequence
  sequence s_one_cycle_access;
    !external_cycle_strobe_n_o ##1 external_cycle_strobe_n_o;
  endsequence

  chk_idle_selects: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R1
    !busy |-> (program_space_strobe_n_o && data_space_strobe_n_o && io_space_strobe_n_o))
    else $error("space select low while idle");
  chk_one_select: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R1
    busy |-> $onehot({~program_space_strobe_n_o, ~data_space_strobe_n_o, ~io_space_strobe_n_o}))
    else $error("not exactly one space select low");
  chk_dir_pair: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R2
    (read_write_o == 1'b0) |-> (!write_strobe_n_o && write_read_o))
    else $error("direction low outside a write");
  chk_read_strobe: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R4
    !read_strobe_n_o |-> (read_write_o && !external_cycle_strobe_n_o))
    else $error("read strobe without read cycle");
  chk_write_drive: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R5
    $fell(write_strobe_n_o) |-> $fell(external_data_bus_oe_n_o))
    else $error("write strobe fall not aligned with data drive");
  chk_zero_wait: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R8
    s_launch_ws0 |=> s_one_cycle_access)
    else $error("zero wait access not one cycle");
  chk_ready_stall: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R7
    (ready_sample && !ready_i) |=> (busy && $stable(ext_addr_o)))
    else $error("access ended while ready low");
  chk_ready_end: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R7
    (ready_sample && ready_i) |=> !busy)
    else $error("access not ended on ready");
  chk_access_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R18
    (busy && !acc_done) |=> ($stable(space_reg) && $stable(write_reg) && busy))
    else $error("access controls changed mid cycle");
  chk_illegal_data: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R12
    (go && !busy && !if_en) |=> (!busy && (illegal_reg || go_space != 2'h1) ##0
    external_cycle_strobe_n_o))
    else $error("disabled interface started a cycle");
  chk_vis_enable: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R13
    !visibility_output_enable_n_o |-> (!external_data_bus_oe_n_o && vis_reg))
    else $error("visibility enable without data drive");
  chk_boot_copy: assert property (@(posedge clk_i) // see R11
    !rstn_i |=> (boot_reg == $past(boot_memory_select_i)))
    else $error("boot select not captured");
  chk_float_cond: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R17
    bus_ctrl_oe_n_o |-> (emulation_pin_0_i && !test_reset_i && !emulation_pin_1_off_i))
    else $error("bus control floated outside emulation");
  chk_wait_load: assert property (@(posedge clk_i) disable iff (!rstn_i) // see R8
    launch |=> (wait_count == $past(ws_sel)))
    else $error("wait count not loaded at launch");

endmodule : emb_bus_ctrl

// file: rtl/emb_params.svh
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH

// Register byte offsets
`define EMB_OFF_WAIT_CTRL   8'h00
`define EMB_OFF_SYS_CS2     8'h04
`define EMB_OFF_ADDR        8'h08
`define EMB_OFF_WDATA       8'h0C
`define EMB_OFF_CTRL        8'h10
`define EMB_OFF_STATUS      8'h14
`define EMB_OFF_RDATA       8'h18

// Field positions
`define EMB_WS_PROG_LSB     0
`define EMB_WS_DATA_LSB     3
`define EMB_WS_IO_LSB       6
`define EMB_WS_W            3
`define EMB_BOOT_BIT        2
`define EMB_CTRL_SPACE_LSB  0
`define EMB_CTRL_WRITE_BIT  2
`define EMB_CTRL_GO_BIT     3
`define EMB_CTRL_VIS_BIT    4
`define EMB_ST_BUSY_BIT     0
`define EMB_ST_DONE_BIT     1
`define EMB_ST_ILL_BIT      2

// Reset values and constants
`define EMB_WAIT_RESET      9'h000
`define EMB_RESET_VECTOR    16'h0000
`define EMB_RESP_OKAY       2'h0
`define EMB_RESP_SLVERR     2'h2
`define EMB_WS_ZERO         3'h0
`define EMB_ONE             3'h1

`endif

// file: rtl/emb_pkg.sv
package emb_pkg;

  typedef enum logic [1:0] {
    EMB_SPACE_PROG,
    EMB_SPACE_DATA,
    EMB_SPACE_IO,
    EMB_SPACE_BAD
  } emb_space_e;

  typedef enum logic {
    EMB_IDLE,
    EMB_ACCESS
  } emb_state_e;

endpackage : emb_pkg

// file: rtl/emb_wait_gen.sv
`timescale 1ns/1ns
`include "emb_params.svh"

module emb_wait_gen (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [2:0] ws_i,
  input  wire logic       ready_i,
  // Status
  output logic            done_o,
  output logic [2:0]      count_o,
  output logic            sample_o
);

  logic       active_reg;
  logic       active_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       use_ready_reg;
  logic       cnt_zero;

  assign cnt_zero = (cnt_reg == `EMB_WS_ZERO);
  // Ready is looked at only once the programmed wait states have run out
  assign sample_o = active_reg & cnt_zero & use_ready_reg;             // see R8
  // Not ready: one more cycle, then ready is sampled again
  assign done_o   = active_reg & cnt_zero & (~use_ready_reg | ready_i); // see R7
  assign count_o  = cnt_reg;

  always_comb begin
    active_next = active_reg;
    cnt_next    = cnt_reg;
    if (start_i) begin
      active_next = 1'b1;
      cnt_next    = ws_i;
    end else if (done_o) begin
      active_next = 1'b0;
    end else if (active_reg && !cnt_zero) begin
      cnt_next = cnt_reg - `EMB_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      active_reg    <= 1'b0;
      cnt_reg       <= `EMB_WS_ZERO;
      use_ready_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      cnt_reg    <= cnt_next;
      if (start_i) begin
        use_ready_reg <= (ws_i != `EMB_WS_ZERO); // see R8
      end
    end
  end

endmodule : emb_wait_gen

// file: verification/emb_ext_mem.sv
`timescale 1ns/1ns

module emb_ext_mem (
  // Clock
  input  wire logic        clk_i,
  // Bus from the device
  input  wire logic [2:0]  sel_n_i,
  input  wire logic        cyc_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        we_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] data_i,
  // Test control
  input  wire logic [3:0]  stall_i,
  // Answers
  output logic             ready_o,
  output logic [15:0]      data_o
);
  logic [15:0] mem [0:2][0:255];
  logic [3:0]  cnt_reg = 4'h0;
  logic [15:0] last_reg = 16'hA5A5;
  logic [1:0]  sp;
  logic        sel;

  assign sp = !sel_n_i[0] ? 2'h0 : (!sel_n_i[1] ? 2'h1 : 2'h2);
  assign sel = (sel_n_i != 3'h7);
  // Held low for the first stall_i cycles of each access; pulled up otherwise
  assign ready_o = !(!cyc_n_i && (cnt_reg < stall_i));
  // Off the bus unless selected and read; a released bus shows a changing pattern
  assign data_o = (!rd_n_i && sel) ? mem[sp][addr_i[7:0]] : ~last_reg;

  always @(posedge clk_i) begin
    cnt_reg <= cyc_n_i ? 4'h0 : cnt_reg + 4'h1;
    last_reg <= data_o;
    if (!we_n_i && sel) begin
      mem[sp][addr_i[7:0]] <= data_i;
    end
  end
endmodule : emb_ext_mem

// file: verification/emb_bus_ctrl_tb.sv
`timescale 1ns/1ns
`include "emb_params.svh"

module emb_bus_ctrl_tb;
  logic        clk_i = 0;
  logic        rstn_i = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        boot = 0, ena = 1, emulation_pin_0 = 0, emu1 = 0, trst = 0;
  logic [3:0]  stall = 0;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, bext, rdy;
  wire  [31:0] rdata;
  wire         ps_n, ds_n, is_n, rw, wrd, rd_n, we_n, cyc_n, ctl_oe_n, vis_n, doe_n;
  wire  [15:0] rvec, addr, dout, mdat, din;
  wire  [40:0] obs;
  int          err_count = 0, checked = 0, nacc = 0;
  integer      seed = 32'h301e8a5d;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [48:0] aq[$];
  logic [7:0]  len = 0, elen = 0;
  logic [40:0] ev = 0;

  always #4 clk_i = ~clk_i;
  // Data wire resolved from both drivers
  assign din = !doe_n ? dout : mdat;
  assign obs = {is_n, ds_n, ps_n, rw, wrd, rd_n, we_n, doe_n, vis_n, addr, we_n ? 16'h0 : din};

  emb_bus_ctrl u_emb_bus_ctrl (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .boot_memory_select_i(boot), .external_interface_enable_pin_i(ena),
    .emulation_pin_0_i(emulation_pin_0), .emulation_pin_1_off_i(emu1), .test_reset_i(trst),
    .ready_i(rdy), .boot_external_o(bext), .reset_vector_o(rvec),
    .program_space_strobe_n_o(ps_n), .data_space_strobe_n_o(ds_n),
    .io_space_strobe_n_o(is_n), .read_write_o(rw), .write_read_o(wrd),
    .read_strobe_n_o(rd_n), .write_strobe_n_o(we_n), .external_cycle_strobe_n_o(cyc_n),
    .bus_ctrl_oe_n_o(ctl_oe_n), .visibility_output_enable_n_o(vis_n),
    .ext_addr_o(addr), .external_data_bus_i(din), .external_data_bus_o(dout),
    .external_data_bus_oe_n_o(doe_n)
  );

  emb_ext_mem u_emb_ext_mem (
    .clk_i(clk_i), .sel_n_i({is_n, ds_n, ps_n}), .cyc_n_i(cyc_n), .rd_n_i(rd_n),
    .we_n_i(we_n), .addr_i(addr), .data_i(din), .stall_i(stall), .ready_o(rdy), .data_o(mdat)
  );

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // Requests are judged on values settled before the edge, avoiding edge races
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb;
    bq.push_back(e);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      @(posedge clk_i);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!tb);
    bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ta, tr;
    rq.push_back(e);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rvalid && rready;
      @(posedge clk_i);
      if (ta) arvalid <= 0;
    end while (!tr);
    rready <= 0;
  endtask : rd

  task automatic access(input logic [1:0] sp, input logic w, input logic [15:0] a,
                        input logic [15:0] d, input logic [2:0] ws, input logic [3:0] st,
                        input logic v);
    int e, n;
    e = (ws == 0) ? 1 : ((st > ws) ? st + 1 : ws + 1);
    stall <= st;
    wr(`EMB_OFF_WAIT_CTRL, 32'(ws) << (3 * sp), `EMB_RESP_OKAY);
    wr(`EMB_OFF_ADDR, {16'h0, a}, `EMB_RESP_OKAY);
    wr(`EMB_OFF_WDATA, {16'h0, d}, `EMB_RESP_OKAY);
    aq.push_back({8'(e), ~(3'h1 << sp), !w, w, w, !w, !w, !(w && v), a, w ? d : 16'h0});
    n = nacc;
    wr(`EMB_OFF_CTRL, {27'h0, v, 1'b1, w, sp}, `EMB_RESP_OKAY);
    for (int i = 0; i < 200 && nacc == n; i++) @(posedge clk_i);
    if (nacc == n) chk(0, 1);
    if (!w) rd(`EMB_OFF_RDATA, {`EMB_RESP_OKAY, 16'h0, d});
  endtask : access

  always @(negedge clk_i) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) chk(1, 0);
      else chk({rresp, rdata}, rq.pop_front());
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) chk(1, 0);
      else chk(bresp, bq.pop_front());
    end
    if (!cyc_n) begin
      if (len == 0) begin
        if (aq.size() == 0) chk(1, 0);
        else {elen, ev} = aq.pop_front();
      end
      chk(obs, ev);
      len = len + 8'h1;
    end else if (len != 0) begin
      chk(len, elen);
      nacc++;
      len = 0;
    end
  end

  initial begin
    logic [1:0]  sp;
    logic [15:0] a, d;
    logic [2:0]  ws, ws2;
    logic [3:0]  st;
    logic        v;
    logic [4:0]  tbl [4];
    tbl = '{5'h1B, 5'h01, 5'h00, 5'h02};
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      boot <= b[0];
      rstn_i <= 0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1;
      boot <= !b[0];
      @(negedge clk_i);
      chk(bext, b);
      chk(rvec, `EMB_RESET_VECTOR);
      rd(`EMB_OFF_SYS_CS2, {`EMB_RESP_OKAY, 29'h0, b[0], 2'h0});
      rd(`EMB_OFF_WAIT_CTRL, {`EMB_RESP_OKAY, 32'h0});
    end
    rd(8'h1C, {`EMB_RESP_SLVERR, 32'h0});
    wr(8'h1C, 32'h0, `EMB_RESP_SLVERR);
    $display("reset and map test done");
    for (int i = 0; i < 12; i++) begin
      sp = 2'(i % 3);
      a = $random(seed);
      d = $random(seed);
      ws = $random(seed);
      ws2 = $random(seed);
      st = 4'($unsigned($random(seed)) % 6);
      v = $random(seed);
      access(sp, 1'b1, a, d, ws, st, v);
      access(sp, 1'b0, a, d, ws2, st, v);
    end
    $display("access test done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      ena <= tbl[k][3];
      wr(`EMB_OFF_CTRL, {28'h0, 2'h2, tbl[k][1:0]}, `EMB_RESP_OKAY);
      repeat (5) @(posedge clk_i);
      rd(`EMB_OFF_STATUS, {`EMB_RESP_OKAY, 29'h0, tbl[k][4] || tbl[k][1:0] == 2'h1, 2'h2});
      wr(`EMB_OFF_STATUS, 32'h6, `EMB_RESP_OKAY);
      rd(`EMB_OFF_STATUS, {`EMB_RESP_OKAY, 32'h0});
    end
    ena <= 1;
    $display("disabled interface test done");
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      {emu1, trst, emulation_pin_0} <= 3'(k);
      @(negedge clk_i);
      chk(ctl_oe_n, k == 1);
    end
    $display("float test done");
    summarize();
  end

  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule : emb_bus_ctrl_tb
